// [pkg/lfrc_pkg.sv]
// constants and register map of the LF receiver mode control block
`default_nettype none
package lfrc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_INDEX = 8'h22;
    localparam logic [7:0] MODE_INDEX = 8'h23;
    localparam int DET_BIT = 7;
    localparam int TOG_BIT = 6;
    localparam int SYNC_LSB = 4;
    localparam int CDT_LSB = 0;
    localparam int MODE_PROG_BIT = 0;
    localparam int MODE_EFF_BIT = 1;
    localparam int MODE_WIN_BIT = 2;
    localparam logic TOG_RESET = 1'b0;
    localparam logic [1:0] SYNC_RESET = 2'h1;
    localparam logic [3:0] CDT_RESET = 4'h0;
    localparam logic MODE_RESET = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : lfrc_pkg
`default_nettype wire

// [pkg/lfrc_det_if.sv]
// detector levels and window events passed from the front end to the core
`timescale 1ns/100ps
`default_nettype none
interface lfrc_det_if;
    logic detector_level;
    logic window_level;
    logic window_start;
    modport front (output detector_level, output window_level,
        output window_start);
    modport core (input detector_level, input window_level,
        input window_start);
endinterface : lfrc_det_if
`default_nettype wire

// [verilog/lfrc_front.sv]
// synchronises the slicer output and the on-window signal into hclk
`timescale 1ns/100ps
`default_nettype none
module lfrc_front (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slicer_out,
    input wire logic on_window,
    lfrc_det_if.front det
);
    import lfrc_pkg::*;
    logic [2:0] slc_q;
    logic [2:0] win_q;
    logic det_q;
    logic next_det;
    logic win_lvl;
    logic next_win;
    logic win_pulse;
    logic next_pulse;

    // slicer path carries no reset at all so no reset can disturb it
    always_ff @(posedge hclk) begin
        slc_q <= {slc_q[1:0], slicer_out};
        win_q <= {win_q[1:0], on_window};
        det_q <= next_det;
    end

    always_comb begin
        next_det = det_q;
        if (slc_q[2] == slc_q[1]) begin
            next_det = slc_q[2];
        end
        next_win = win_lvl;
        if (win_q[2] == win_q[1]) begin
            next_win = win_q[2];
        end
        next_pulse = next_win & ~win_lvl;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_lvl <= 1'b0;
            win_pulse <= 1'b0;
        end else begin
            win_lvl <= next_win;
            win_pulse <= next_pulse;
        end
    end

    assign det.detector_level = det_q;
    assign det.window_level = win_lvl;
    assign det.window_start = win_pulse;

    a_det_agree: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !$stable(det_q) |-> $past(slc_q[2]) == $past(slc_q[1])
        && det_q == $past(slc_q[2]))
        else $error("detector bit moved without agreeing stages");
endmodule : lfrc_front
`default_nettype wire

// [verilog/lfrc_top.sv]
// AHB-Lite control register and mode toggle of the LF receiver
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lfrc_top #(
    parameter int ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic lfr_reset_req,
    input wire logic slicer_out,
    input wire logic on_window,
    output logic carrier_mode,
    output logic mode_toggle_out,
    output logic [1:0] sync_select,
    output logic [3:0] carrier_detect_time
);
    import lfrc_pkg::*;

    if (ADDR_W < 10) begin : g_bad_addr
        $error("ADDR_W must cover the register map");
    end

    function automatic logic hits(input logic [ADDR_W-1:0] a,
        input logic [7:0] idx);
        hits = (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
    endfunction : hits

    lfrc_det_if det ();

    lfrc_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .slicer_out(slicer_out),
        .on_window(on_window),
        .det(det)
    );

    // bus state
    logic dp_write;
    logic dp_read;
    logic rd_done;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rd_q;
    logic next_dp_write;
    logic next_dp_read;
    logic next_rd_done;
    logic [ADDR_W-1:0] next_dp_addr;
    logic [31:0] next_rd_q;
    logic accept;

    // register state
    logic toggle_en;
    logic [1:0] sync_sel;
    logic [3:0] cdt;
    logic mode_prog;
    logic mode_eff;
    logic first_pending;
    logic next_toggle_en;
    logic [1:0] next_sync_sel;
    logic [3:0] next_cdt;
    logic next_mode_prog;
    logic next_mode_eff;
    logic next_first_pending;
    logic wr_ctrl;
    logic wr_mode;
    logic [7:0] ctrl_view;
    logic [7:0] mode_view;

    // reads stall one cycle so that a just-finished write is seen
    assign hreadyout = !(dp_read && !rd_done);
    assign hresp = HRESP_OKAY;
    assign hrdata = rd_q;
    assign accept = hsel && htrans == HTRANS_NONSEQ && hready;

    assign wr_ctrl = dp_write && hready && hits(dp_addr, CTRL_INDEX);
    assign wr_mode = dp_write && hready && hits(dp_addr, MODE_INDEX);

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[DET_BIT] = det.detector_level;
        ctrl_view[TOG_BIT] = toggle_en;
        ctrl_view[SYNC_LSB +: 2] = sync_sel;
        ctrl_view[CDT_LSB +: 4] = cdt;
        mode_view = 8'h00;
        mode_view[MODE_PROG_BIT] = mode_prog;
        mode_view[MODE_EFF_BIT] = mode_eff;
        mode_view[MODE_WIN_BIT] = det.window_level;
    end

    always_comb begin
        next_dp_write = dp_write;
        next_dp_read = dp_read;
        next_dp_addr = dp_addr;
        next_rd_done = rd_done;
        next_rd_q = rd_q;
        if (hready) begin
            next_dp_write = accept && hwrite;
            next_dp_read = accept && !hwrite;
            next_rd_done = 1'b0;
            if (accept) begin
                next_dp_addr = haddr;
            end
        end else if (dp_read && !rd_done) begin
            next_rd_done = 1'b1;
            next_rd_q = 32'h0000_0000;
            if (hits(dp_addr, CTRL_INDEX)) begin
                next_rd_q = {24'h00_0000, ctrl_view};
            end else if (hits(dp_addr, MODE_INDEX)) begin
                next_rd_q = {24'h00_0000, mode_view};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            rd_done <= 1'b0;
            dp_addr <= '0;
            rd_q <= 32'h0000_0000;
        end else begin
            dp_write <= next_dp_write;
            dp_read <= next_dp_read;
            rd_done <= next_rd_done;
            dp_addr <= next_dp_addr;
            rd_q <= next_rd_q;
        end
    end

    // field updates; the receiver reset outranks a bus write
    always_comb begin
        next_toggle_en = toggle_en;
        next_sync_sel = sync_sel;
        next_cdt = cdt;
        next_mode_prog = mode_prog;
        next_mode_eff = mode_eff;
        next_first_pending = first_pending;
        if (lfr_reset_req) begin
            next_toggle_en = TOG_RESET;
            next_sync_sel = SYNC_RESET;
            next_cdt = CDT_RESET;
            next_mode_prog = MODE_RESET;
            next_mode_eff = MODE_RESET;
            next_first_pending = 1'b1;
        end else if (wr_ctrl) begin
            // detector bit is never taken from the write data
            next_toggle_en = hwdata[TOG_BIT];
            next_sync_sel = hwdata[SYNC_LSB +: 2];
            next_cdt = hwdata[CDT_LSB +: 4];
            next_mode_eff = mode_prog;
            next_first_pending = 1'b1;
        end else if (wr_mode) begin
            next_mode_prog = hwdata[MODE_PROG_BIT];
            next_mode_eff = hwdata[MODE_PROG_BIT];
            next_first_pending = 1'b1;
        end else if (!toggle_en) begin
            next_mode_eff = mode_prog;
            next_first_pending = 1'b1;
        end else if (det.window_start) begin
            // first window after arming runs the programmed mode
            if (first_pending) begin
                next_first_pending = 1'b0;
            end else begin
                next_mode_eff = !mode_eff;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            toggle_en <= TOG_RESET;
            sync_sel <= SYNC_RESET;
            cdt <= CDT_RESET;
            mode_prog <= MODE_RESET;
            mode_eff <= MODE_RESET;
            first_pending <= 1'b1;
        end else begin
            toggle_en <= next_toggle_en;
            sync_sel <= next_sync_sel;
            cdt <= next_cdt;
            mode_prog <= next_mode_prog;
            mode_eff <= next_mode_eff;
            first_pending <= next_first_pending;
        end
    end

    // one selects carrier detect, zero selects data receive
    assign carrier_mode = mode_eff;
    assign mode_toggle_out = toggle_en;
    assign sync_select = sync_sel;
    assign carrier_detect_time = cdt;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_det_readback: assert property (
        dp_read && !rd_done && hits(dp_addr, CTRL_INDEX)
        |=> hrdata[DET_BIT] == $past(det.detector_level))
        else $error("detector bit not shown on read");

    a_det_level_read: assert property (
        dp_read && !rd_done && hits(dp_addr, CTRL_INDEX)
        && det.detector_level |=> hrdata[7:6] >= 2'h2 && hreadyout)
        else $error("high detector level read as low");

    a_toggle_reset: assert property (
        lfr_reset_req |=> !toggle_en && !mode_toggle_out)
        else $error("toggle enable survived reset");

    a_mode_steady: assert property (
        !toggle_en && !wr_mode && !lfr_reset_req ##1 !toggle_en
        |-> carrier_mode == mode_prog && $stable(mode_prog))
        else $error("mode moved with toggling off");

    a_mode_flip: assert property (
        toggle_en && det.window_start && !first_pending
        && !wr_ctrl && !wr_mode && !lfr_reset_req
        |=> carrier_mode != $past(carrier_mode))
        else $error("mode not inverted at new window");

    a_first_window: assert property (
        toggle_en && det.window_start && first_pending
        && !wr_ctrl && !wr_mode && !lfr_reset_req
        |=> carrier_mode == $past(mode_eff) && !first_pending)
        else $error("first window did not keep programmed mode");

    a_ctrl_write: assert property (
        wr_ctrl && !lfr_reset_req |=> sync_select == $past(hwdata[5:4])
        && carrier_detect_time == $past(hwdata[3:0]))
        else $error("control write not stored");

    a_read_wait: assert property (
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer timing wrong");

    a_sync_reset: assert property (
        lfr_reset_req |=> sync_select == 2'h1)
        else $error("sync selection not preset to 01");

    a_cdt_reset: assert property (
        lfr_reset_req |=> carrier_detect_time == 4'h0)
        else $error("carrier detect time not cleared");

    a_det_low_read: assert property (
        dp_read && !rd_done && hits(dp_addr, CTRL_INDEX)
        && !det.detector_level |=> !hrdata[DET_BIT])
        else $error("low detector level read as high");

    a_toggle_write: assert property (
        wr_ctrl && !lfr_reset_req
        |=> mode_toggle_out == $past(hwdata[TOG_BIT]))
        else $error("toggle enable write not stored");

    a_mode_follow: assert property (
        !toggle_en && !wr_ctrl && !wr_mode && !lfr_reset_req
        |=> carrier_mode == $past(mode_prog))
        else $error("mode left programmed value with toggling off");

    a_mode_hold: assert property (
        toggle_en && !det.window_start && !wr_ctrl && !wr_mode
        && !lfr_reset_req |=> $stable(carrier_mode))
        else $error("mode moved between windows");

    a_mode_rearm: assert property (
        wr_ctrl && !lfr_reset_req
        |=> carrier_mode == $past(mode_prog) && first_pending)
        else $error("control write did not rearm toggling");

    a_first_hold: assert property (
        toggle_en && det.window_start && !wr_ctrl && !wr_mode
        && !lfr_reset_req |=> !first_pending)
        else $error("window did not end the first-window phase");

    a_reset_rearm: assert property (
        lfr_reset_req |=> first_pending && carrier_mode == MODE_RESET)
        else $error("receiver reset did not rearm mode");

    a_mode_write: assert property (
        wr_mode && !lfr_reset_req
        |=> carrier_mode == $past(hwdata[MODE_PROG_BIT]))
        else $error("programmed mode write not applied");

    a_write_ready: assert property (
        dp_write |-> hreadyout)
        else $error("write data phase stalled");

    a_unmapped_read: assert property (
        dp_read && !rd_done && !hits(dp_addr, CTRL_INDEX)
        && !hits(dp_addr, MODE_INDEX) |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_upper_zero: assert property (
        rd_done |-> hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
endmodule : lfrc_top
`default_nettype wire

// [verif/lfrc_front_model.sv]
// behavioural LF front end: slicer level and detector on-window pulses
`timescale 1ns/100ps
`default_nettype none
module lfrc_front_model (
    input wire logic hclk,
    input wire logic carrier_on,
    input wire logic window_req,
    output logic slicer_out,
    output logic on_window
);
    int win_cnt = 0;
    // slicer is high only while a carrier is present
    assign slicer_out = carrier_on;
    // each request opens one on-window six cycles long
    assign on_window = (win_cnt != 0);
    always @(posedge hclk) begin
        if (window_req) begin
            win_cnt <= 6;
        end else if (win_cnt != 0) begin
            win_cnt <= win_cnt - 1;
        end
    end
endmodule : lfrc_front_model
`default_nettype wire

// [verif/testbench.sv]
// register and mode toggle tests of the LF receiver control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import lfrc_pkg::*;
    localparam logic [31:0] CTRL_A = {22'h0, CTRL_INDEX, 2'h0};
    localparam logic [31:0] MODE_A = {22'h0, MODE_INDEX, 2'h0};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic lfr_reset_req = 1'b0;
    logic carrier_on = 1'b0;
    logic window_req = 1'b0;
    logic rdy_s = 1'b1;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic slicer_out;
    wire logic on_window;
    wire logic carrier_mode;
    wire logic mode_toggle_out;
    wire logic [1:0] sync_select;
    wire logic [3:0] carrier_detect_time;
    int bad_count = 0;
    int samples_checked = 0;

    lfrc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .lfr_reset_req(lfr_reset_req),
        .slicer_out(slicer_out), .on_window(on_window),
        .carrier_mode(carrier_mode), .mode_toggle_out(mode_toggle_out),
        .sync_select(sync_select),
        .carrier_detect_time(carrier_detect_time));
    lfrc_front_model front_u (.hclk(hclk), .carrier_on(carrier_on),
        .window_req(window_req), .slicer_out(slicer_out),
        .on_window(on_window));

    always #10 hclk = ~hclk;
    // settled ready level, seen by the master at the next rising edge
    always @(negedge hclk) rdy_s = hreadyout;

    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (rdy_s !== 1'b1 && n < 50);
        if (rdy_s !== 1'b1) begin
            bad_count++;
            $display("MISMATCH hready expected 1 seen %b", rdy_s);
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string what, input logic [31:0] a,
        input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask : rd

    task automatic win();
        @(posedge hclk);
        window_req <= 1'b1;
        @(posedge hclk);
        window_req <= 1'b0;
        repeat (16) @(posedge hclk);
    endtask : win

    task automatic outs(input string what, input logic [7:0] exp);
        // registered outputs are settled by the falling edge
        @(negedge hclk);
        check(what, {24'h0, exp}, {24'h0, carrier_mode, mode_toggle_out,
            sync_select, carrier_detect_time});
    endtask : outs

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        outs("reset outputs", 8'h90);
        rd("ctrl reset", CTRL_A, 32'h10);
        rd("unmapped", 32'h90, 32'h0);
        wr(CTRL_A, 32'hFF);
        rd("ctrl written", CTRL_A, 32'h7F);
        carrier_on <= 1'b1;
        repeat (8) @(posedge hclk);
        rd("detector high", CTRL_A, 32'hFF);
        @(posedge hclk);
        lfr_reset_req <= 1'b1;
        @(posedge hclk);
        lfr_reset_req <= 1'b0;
        rd("receiver reset", CTRL_A, 32'h90);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        rd("bus reset", CTRL_A, 32'h90);
        carrier_on <= 1'b0;
        repeat (8) @(posedge hclk);
        rd("detector low", CTRL_A, 32'h10);
        wr(MODE_A, 32'h0);
        win();
        win();
        rd("mode fixed", MODE_A, 32'h0);
        outs("data mode", 8'h10);
        wr(MODE_A, 32'h1);
        wr(CTRL_A, 32'h40);
        outs("toggle armed", 8'hC0);
        win();
        outs("window one", 8'hC0);
        win();
        outs("window two", 8'h40);
        rd("mode toggled", MODE_A, 32'h1);
        win();
        outs("window three", 8'hC0);
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
